// ==== include/goc_pkg.sv ====
// package: register map, option byte layouts, carriers and timing of the gauge option bank
package goc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int AW = 9;
  localparam logic [8:0] OFS_GAUGE = 9'h029;
  localparam logic [8:0] OFS_MISC_HI = 9'h02A;
  localparam logic [8:0] OFS_MISC_LO = 9'h02B;
  localparam logic [8:0] OFS_MISC2 = 9'h139;
  localparam logic [8:0] OFS_STATUS = 9'h1F0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // writable bits of the three misc bytes, and fixed-one bits of the high misc byte only
  localparam logic [7:0] MISC_HI_KEEP = 8'hBD;
  localparam logic [7:0] MISC_HI_ONES = 8'h02;
  localparam logic [7:0] MISC_LO_KEEP = 8'hF9;
  localparam logic [7:0] MISC2_KEEP = 8'h3F;

  // ----------------------------------------------------------------
  // encodings and values
  // ----------------------------------------------------------------
  localparam logic [1:0] PRE_ZV = 2'h0;
  localparam logic [1:0] PRE_CHG = 2'h1;
  localparam logic [1:0] PRE_OD = 2'h2;
  localparam logic [2:0] SW_NONE = 3'h0;
  localparam logic [2:0] SW_ZV = 3'h1;
  localparam logic [2:0] SW_CHG = 3'h2;
  localparam logic [2:0] SW_OD = 3'h4;
  localparam logic [7:0] CELL_CMD_STD = 8'h3C;
  localparam logic [7:0] CELL_CMD_ALT = 8'h38;
  localparam logic [4:0] MAKER_SHORT = 5'h0B;
  localparam logic [4:0] PRODUCT_SHORT = 5'h07;
  localparam logic [4:0] LONG_EXTRA = 5'h0F;
  localparam logic [4:0] EXTRA_NONE = 5'h00;
  localparam logic [7:0] SOC_CAP = 8'h63;
  localparam logic [23:0] PCT_FULL = 24'h000064;
  localparam logic [15:0] VALUE_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned SLEEP_MS = 2000;
  localparam longint unsigned VDELAY_MS = 1000;
  localparam longint unsigned FAULT_RESET_S = 30;
  localparam longint unsigned SLEEP_CYC_DEF = SLEEP_MS * CLK_HZ / 1000;
  localparam longint unsigned VDELAY_CYC_DEF = VDELAY_MS * CLK_HZ / 1000;
  localparam longint unsigned FAULT_CYC_DEF = FAULT_RESET_S * CLK_HZ;

  // ----------------------------------------------------------------
  // option byte layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fix_lowest_threshold;
    logic capacity_sync_on_term;
    logic learn_charger_type;
    logic threshold_compensation;
    logic discharge_voltage_select;
    logic overvoltage_select;
    logic continuous_midrange;
    logic one_time_midrange;
  } goc_gauge_s;

  typedef struct packed {
    logic internal_sensor_sel;
    logic rsv_zero;
    logic front_end_check;
    logic sleep_disable;
    logic overtemp_action;
    logic led_in_charge;
    logic rsv_one;
    logic voltage_flag_delay;
  } goc_misc_hi_s;

  typedef struct packed {
    logic alarm_led_dark;
    logic precharge_sel_hi;
    logic precharge_sel_lo;
    logic nonremovable_pack;
    logic charge_switch_hold;
    logic [1:0] rsv_zero;
    logic discharge_switch_hold;
  } goc_misc_lo_s;

  typedef struct packed {
    logic [1:0] rsv_zero;
    logic long_string;
    logic alternate_cell_command;
    logic zero_current_on_discharge;
    logic charge_percent_limit;
    logic zero_voltage_on_full;
    logic depleted_charge_on;
  } goc_misc2_s;

  // ----------------------------------------------------------------
  // carriers to and from the gauge logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] lowest_end_threshold;
    logic [15:0] middle_end_threshold;
    logic [15:0] upper_end_threshold;
    logic [15:0] comp_lowest;
    logic [15:0] comp_middle;
    logic [15:0] comp_upper;
    logic [15:0] lowest_cell_mv;
    logic [15:0] highest_cell_mv;
    logic [15:0] pack_mv;
    logic [2:0] cell_count;
    logic [15:0] safety_ov_limit;
    logic [15:0] full_charge_capacity;
    logic [7:0] sync_percent;
    logic term_valid;
    logic midrange_done;
    logic afe_comm_error;
    logic pf_front_end_enable;
    logic ot_charge;
    logic ot_discharge;
    logic discharging_flag;
    logic fully_charged_flag;
    logic cap_alarm;
    logic cell_over_raw;
    logic cell_under_raw;
    logic precharge_req;
    logic depleted_mode;
    logic [15:0] precharge_threshold;
    logic fail_chg_set;
    logic fail_dsg_set;
    logic current_charge;
    logic current_discharge;
    logic avg_below_clear;
    logic [15:0] chg_current_req;
    logic [15:0] chg_voltage_req;
    logic [7:0] relative_charge_percent;
    logic [7:0] absolute_charge_percent;
  } goc_meas_s;

  typedef struct packed {
    logic [15:0] eff_lowest;
    logic [15:0] eff_middle;
    logic [15:0] eff_upper;
    logic [15:0] edv_voltage;
    logic edv_reached;
    logic safety_over;
    logic rm_load;
    logic [15:0] rm_load_value;
    logic midrange_run;
    logic one_time_done;
    logic learn_charger_type;
    logic temp_internal;
    logic afe_verify;
    logic fe_perm_fail;
    logic sleep_active;
    logic chg_fet_on;
    logic dsg_fet_on;
    logic [2:0] precharge_switch;
    logic led_on;
    logic led_blink;
    logic cell_over_flag;
    logic cell_under_flag;
    logic [4:0] maker_len_max;
    logic [4:0] product_len_max;
    logic [7:0] cell_cmd_base;
    logic [15:0] chg_current_rpt;
    logic [15:0] chg_voltage_rpt;
    logic [7:0] relative_charge_percent;
    logic [7:0] absolute_charge_percent;
    logic fail_chg;
    logic fail_dsg;
    logic term_seen;
  } goc_out_s;

endpackage

// ==== design/goc_sync.sv ====
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module goc_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // pins in, synchronised out
  input wire logic [2:0] d_in,
  output logic [2:0] q_out
);
  import goc_pkg::*;
  logic [2:0] meta;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= 3'h0;
      q_out <= 3'h0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule

// ==== design/goc_timer.sv ====
// hold timer: done rises once run has stayed high for CYC cycles
`timescale 1ns/1ps
module goc_timer #(
  parameter longint unsigned CYC = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // control
  input wire logic run,
  output logic done
);
  import goc_pkg::*;
  localparam logic [31:0] LAST = 32'(CYC - 1);
  logic [31:0] cnt;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 32'h0;
      done <= 1'b0;
    end else if (!run) begin
      cnt <= 32'h0;
      done <= 1'b0;
    end else if (cnt == LAST) begin
      done <= 1'b1;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end
endmodule

// ==== design/goc_top.sv ====
// gauge option bank: option storage, sampled options and the control they steer
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module goc_top #(
  parameter longint unsigned SLEEP_CYC = goc_pkg::SLEEP_CYC_DEF,
  parameter longint unsigned VDELAY_CYC = goc_pkg::VDELAY_CYC_DEF,
  parameter longint unsigned FAULT_CYC = goc_pkg::FAULT_CYC_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic [goc_pkg::AW-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rd_data,
  // pins
  input wire logic smbus_clk_pin,
  input wire logic smbus_data_pin,
  input wire logic sys_present_pin,
  // gauge logic
  input wire goc_pkg::goc_meas_s meas,
  output goc_pkg::goc_out_s ctl
);
  import goc_pkg::*;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic [7:0] store_gauge;
  logic [7:0] store_misc_hi;
  logic [7:0] store_misc_lo;
  logic [7:0] store_misc2;
  wire logic sel_gauge = addr == OFS_GAUGE;
  wire logic sel_misc_hi = addr == OFS_MISC_HI;
  wire logic sel_misc_lo = addr == OFS_MISC_LO;
  wire logic sel_misc2 = addr == OFS_MISC2;
  wire logic sel_status = addr == OFS_STATUS;
  wire logic [7:0] status = {3'h0, ctl.sleep_active, ctl.fail_chg, ctl.fail_dsg,
    ctl.term_seen, ctl.one_time_done};
  wire logic [7:0] rd_mux = sel_gauge ? store_gauge :
    sel_misc_hi ? store_misc_hi :
    sel_misc_lo ? store_misc_lo :
    sel_misc2 ? store_misc2 :
    sel_status ? status : BYTE_ZERO;

  // storage models the nonvolatile bytes, so reset leaves it alone
  always_ff @(posedge sys_clk) begin
    if (wr_stb && sel_gauge) begin
      store_gauge <= wr_data;
    end
    if (wr_stb && sel_misc_hi) begin
      store_misc_hi <= (wr_data & MISC_HI_KEEP) | MISC_HI_ONES;
    end
    if (wr_stb && sel_misc_lo) begin
      store_misc_lo <= wr_data & MISC_LO_KEEP;
    end
    if (wr_stb && sel_misc2) begin
      store_misc2 <= wr_data & MISC2_KEEP;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= BYTE_ZERO;
    end else begin
      rd_data <= rd_stb ? rd_mux : BYTE_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // option sampling
  // ----------------------------------------------------------------
  goc_gauge_s opt_g;
  goc_misc_hi_s opt_h;
  goc_misc_lo_s opt_l;
  goc_misc2_s opt_2;
  logic loaded;

  // sampled once; later writes only take effect after the next reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      loaded <= 1'b0;
      opt_g <= '0;
      opt_h <= '0;
      opt_l <= '0;
      opt_2 <= '0;
    end else if (!loaded) begin
      loaded <= 1'b1;
      opt_g <= store_gauge;
      opt_h <= store_misc_hi;
      opt_l <= store_misc_lo;
      opt_2 <= store_misc2;
    end
  end

  // ----------------------------------------------------------------
  // pins and timers
  // ----------------------------------------------------------------
  logic [2:0] pin_s;
  logic present_q;
  logic sleep_done;
  logic over_done;
  logic under_done;
  logic fault_done;

  goc_sync u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .d_in({sys_present_pin, smbus_data_pin, smbus_clk_pin}),
    .q_out(pin_s)
  );

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      present_q <= 1'b0;
    end else begin
      present_q <= pin_s[2];
    end
  end

  // pack removal shows as the present pin going high
  wire logic present_rise = pin_s[2] && !present_q;
  wire logic bus_low = !pin_s[0] && !pin_s[1];
  wire logic nr = opt_l.nonremovable_pack;
  wire logic any_fail = ctl.fail_chg || ctl.fail_dsg;

  goc_timer #(.CYC(SLEEP_CYC)) u_sleep (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .run(loaded && bus_low && !opt_h.sleep_disable),
    .done(sleep_done)
  );

  goc_timer #(.CYC(VDELAY_CYC)) u_over (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .run(meas.cell_over_raw),
    .done(over_done)
  );

  goc_timer #(.CYC(VDELAY_CYC)) u_under (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .run(meas.cell_under_raw),
    .done(under_done)
  );

  goc_timer #(.CYC(FAULT_CYC)) u_fault (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .run(nr && any_fail && meas.avg_below_clear),
    .done(fault_done)
  );

  // ----------------------------------------------------------------
  // thresholds and voltage selection
  // ----------------------------------------------------------------
  wire logic comp = opt_g.threshold_compensation;
  wire logic fix = opt_g.fix_lowest_threshold;
  wire logic [15:0] low_th = (!comp || fix) ? meas.lowest_end_threshold : meas.comp_lowest;
  wire logic [15:0] mid_th = !comp ? meas.middle_end_threshold :
    (fix && meas.comp_middle < low_th) ? low_th : meas.comp_middle;
  wire logic [15:0] up_th = !comp ? meas.upper_end_threshold :
    (fix && meas.comp_upper < low_th) ? low_th : meas.comp_upper;
  wire logic [15:0] edv_v = opt_g.discharge_voltage_select ?
    meas.pack_mv : meas.lowest_cell_mv;
  wire logic [18:0] ov_prod = 19'({3'h0, meas.highest_cell_mv} * {16'h0000, meas.cell_count});
  wire logic [18:0] ov_v = opt_g.overvoltage_select ?
    ov_prod : {3'h0, meas.pack_mv};
  wire logic [23:0] rm_prod = 24'({8'h00, meas.full_charge_capacity} *
    {16'h0000, meas.sync_percent}) / PCT_FULL;

  // ----------------------------------------------------------------
  // failures, fets and precharge
  // ----------------------------------------------------------------
  // set wins over clear so a failure seen in the clearing cycle stays latched
  wire logic clr_chg = present_rise || (nr && (meas.current_discharge || fault_done));
  wire logic clr_dsg = present_rise || (nr && (meas.current_charge || fault_done));
  wire logic ot_en = opt_h.overtemp_action;
  wire logic ot_cut_chg = ot_en && (meas.ot_charge || meas.ot_discharge);
  wire logic ot_cut_dsg = ot_en && (meas.ot_discharge ||
    (meas.ot_charge && !opt_l.discharge_switch_hold));
  wire logic dep_on = opt_2.depleted_charge_on && meas.depleted_mode &&
    meas.lowest_cell_mv > meas.precharge_threshold;
  wire logic chg_off = ot_cut_chg || (ctl.term_seen && !opt_l.charge_switch_hold) ||
    ctl.fail_chg || (ctl.fail_dsg && !nr);
  wire logic dsg_off = ot_cut_dsg || ctl.fail_dsg || (ctl.fail_chg && !nr);
  wire logic [1:0] pre_code = {opt_l.precharge_sel_hi, opt_l.precharge_sel_lo};
  // the undefined code drives no switch rather than guess one
  wire logic [2:0] pre_sw = !meas.precharge_req ? SW_NONE :
    (pre_code == PRE_ZV) ? SW_ZV :
    (pre_code == PRE_CHG) ? SW_CHG :
    (pre_code == PRE_OD) ? SW_OD : SW_NONE;

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  wire logic leds_allowed = meas.discharging_flag || opt_h.led_in_charge;
  wire logic soc_capped = opt_2.charge_percent_limit && !ctl.term_seen;
  wire logic [4:0] name_extra = opt_2.long_string ? LONG_EXTRA : EXTRA_NONE;

  goc_out_s next_ctl;

  always_comb begin
    next_ctl = ctl;
    next_ctl.eff_lowest = low_th;
    next_ctl.eff_middle = mid_th;
    next_ctl.eff_upper = up_th;
    next_ctl.edv_voltage = edv_v;
    next_ctl.edv_reached = edv_v < low_th;
    next_ctl.safety_over = ov_v > {3'h0, meas.safety_ov_limit};
    next_ctl.rm_load = meas.term_valid && opt_g.capacity_sync_on_term;
    next_ctl.rm_load_value = rm_prod[15:0];
    next_ctl.midrange_run = opt_g.continuous_midrange ||
      (opt_g.one_time_midrange && !ctl.one_time_done);
    next_ctl.one_time_done = ctl.one_time_done ||
      (meas.midrange_done && opt_g.one_time_midrange);
    next_ctl.learn_charger_type = opt_g.learn_charger_type;
    next_ctl.temp_internal = opt_h.internal_sensor_sel;
    next_ctl.afe_verify = opt_h.front_end_check;
    next_ctl.fe_perm_fail = ctl.fe_perm_fail || (opt_h.front_end_check &&
      meas.pf_front_end_enable && meas.afe_comm_error);
    next_ctl.sleep_active = sleep_done;
    next_ctl.chg_fet_on = dep_on ? !ot_cut_chg : !chg_off;
    next_ctl.dsg_fet_on = !dsg_off;
    next_ctl.precharge_switch = pre_sw;
    next_ctl.led_on = leds_allowed && !(meas.cap_alarm && opt_l.alarm_led_dark);
    next_ctl.led_blink = leds_allowed && meas.cap_alarm && !opt_l.alarm_led_dark;
    next_ctl.cell_over_flag = opt_h.voltage_flag_delay ? over_done : meas.cell_over_raw;
    next_ctl.cell_under_flag = opt_h.voltage_flag_delay ? under_done : meas.cell_under_raw;
    next_ctl.maker_len_max = 5'(MAKER_SHORT + name_extra);
    next_ctl.product_len_max = 5'(PRODUCT_SHORT + name_extra);
    next_ctl.cell_cmd_base = opt_2.alternate_cell_command ? CELL_CMD_ALT : CELL_CMD_STD;
    next_ctl.chg_current_rpt = (opt_2.zero_current_on_discharge && meas.discharging_flag) ?
      VALUE_ZERO : meas.chg_current_req;
    next_ctl.chg_voltage_rpt = (opt_2.zero_voltage_on_full && meas.fully_charged_flag) ?
      VALUE_ZERO : meas.chg_voltage_req;
    next_ctl.relative_charge_percent = (soc_capped && meas.relative_charge_percent > SOC_CAP) ?
      SOC_CAP : meas.relative_charge_percent;
    next_ctl.absolute_charge_percent = (soc_capped && meas.absolute_charge_percent > SOC_CAP) ?
      SOC_CAP : meas.absolute_charge_percent;
    next_ctl.fail_chg = meas.fail_chg_set || (ctl.fail_chg && !clr_chg);
    next_ctl.fail_dsg = meas.fail_dsg_set || (ctl.fail_dsg && !clr_dsg);
    next_ctl.term_seen = meas.term_valid || (ctl.term_seen && !meas.discharging_flag);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl <= '0;
    end else begin
      ctl <= next_ctl;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_lowest_clamp: assert property (
    loaded && fix && comp |=> ctl.eff_middle >= ctl.eff_lowest && ctl.eff_upper >= ctl.eff_lowest)
    else $error("compensated threshold below lowest threshold");

  a_sync_load: assert property (
    loaded && meas.term_valid |=> ctl.rm_load == $past(opt_g.capacity_sync_on_term))
    else $error("capacity load does not follow sync option");

  a_stored_thresh: assert property (
    loaded && !comp |=> ctl.eff_upper == $past(meas.upper_end_threshold))
    else $error("stored upper threshold not used");

  a_edv_source: assert property (
    loaded |=> ctl.edv_voltage == ($past(opt_g.discharge_voltage_select) ?
      $past(meas.pack_mv) : $past(meas.lowest_cell_mv)))
    else $error("wrong discharge end voltage source");

  a_sleep_never: assert property (
    loaded && opt_h.sleep_disable |=> !ctl.sleep_active)
    else $error("sleep entered while disabled");

  a_ot_charge_cut: assert property (
    loaded && ot_en && meas.ot_charge |=> !ctl.chg_fet_on)
    else $error("charge fet on during overtemperature");

  a_dsg_hold: assert property (
    loaded && ot_en && meas.ot_charge && !opt_l.discharge_switch_hold |=> !ctl.dsg_fet_on)
    else $error("discharge fet on during charge overtemperature");

  a_vflag_direct: assert property (
    loaded && !opt_h.voltage_flag_delay |=> ctl.cell_over_flag == $past(meas.cell_over_raw))
    else $error("cell over flag delayed while delay off");

  a_precharge_sel: assert property (
    loaded && meas.precharge_req && pre_code == PRE_CHG |=> ctl.precharge_switch == SW_CHG)
    else $error("precharge did not select charge fet");

  a_removal_clear: assert property (
    present_rise && !meas.fail_chg_set |=> !ctl.fail_chg)
    else $error("failure not cleared on pack removal");

  a_soc_cap: assert property (
    loaded && soc_capped |=> ctl.relative_charge_percent <= SOC_CAP)
    else $error("relative charge above cap before termination");

  a_opt_hold: assert property (
    loaded |=> loaded && $stable(opt_g) && $stable(opt_h) && $stable(opt_l) && $stable(opt_2))
    else $error("options changed after sampling");

  a_rd_answer: assert property (
    rd_stb && sel_gauge |=> rd_data == $past(store_gauge) ##1
      ($past(rd_stb) || rd_data == BYTE_ZERO))
    else $error("read answer wrong or held too long");

endmodule

// ==== tb/tb_top.sv ====
// testbench for the gauge option bank: storage, sampling after reset and option decode
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))
module tb_top;
  import goc_pkg::*;
  // ----------------------------------------------------------------
  // clock, stimulus and design
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wr_data = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rd_data;
  logic smbus_clk_pin = 1'b1;
  logic smbus_data_pin = 1'b1;
  logic sys_present_pin = 1'b0;
  goc_meas_s meas = '0;
  goc_out_s ctl;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h000006A4;
  logic [31:0] d;
  logic [7:0] g, h, l, m;
  always #5 sys_clk = ~sys_clk;
  // short timer values keep the run brief
  goc_top #(.SLEEP_CYC(20), .VDELAY_CYC(10), .FAULT_CYC(15)) u_goc_top (.sys_clk(sys_clk),
    .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .smbus_clk_pin(smbus_clk_pin), .smbus_data_pin(smbus_data_pin),
    .sys_present_pin(sys_present_pin), .meas(meas), .ctl(ctl));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    `CHK(rd_data, exp);
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      {m, l, h, g} = d;
      // storage is only sampled at reset, so write while running then reset
      wr(OFS_GAUGE, g);
      wr(OFS_MISC_HI, h);
      wr(OFS_MISC_LO, l);
      wr(OFS_MISC2, m);
      rd(OFS_GAUGE, g);
      rd(OFS_MISC_HI, (h & MISC_HI_KEEP) | MISC_HI_ONES);
      rd(OFS_MISC_LO, l & MISC_LO_KEEP);
      rd(OFS_MISC2, m & MISC2_KEEP);
      rd(9'h000, BYTE_ZERO);
      @(posedge sys_clk);
      d = rnd();
      meas <= '{lowest_cell_mv: d[15:0], pack_mv: d[31:16], chg_current_req: ~d[15:0],
        chg_voltage_req: ~d[31:16], lowest_end_threshold: d[31:16] ^ 16'h00FF,
        middle_end_threshold: d[15:0] ^ 16'h0F0F, relative_charge_percent: 8'h64,
        absolute_charge_percent: 8'h64,
        discharging_flag: 1'b1, fully_charged_flag: 1'b1, precharge_req: 1'b1,
        cap_alarm: d[0], default: '0};
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK(ctl.edv_voltage, g[3] ? meas.pack_mv : meas.lowest_cell_mv);
      if (!g[4] || g[7])
        `CHK(ctl.eff_lowest, meas.lowest_end_threshold);
      if (!g[4])
        `CHK(ctl.eff_middle, meas.middle_end_threshold);
      `CHK(ctl.temp_internal, h[7]);
      `CHK(ctl.afe_verify, h[5]);
      `CHK(ctl.midrange_run, g[1] || g[0]);
      `CHK(ctl.learn_charger_type, g[5]);
      `CHK(ctl.led_on, !(d[0] && l[7]));
      `CHK(ctl.led_blink, d[0] && !l[7]);
      `CHK(ctl.precharge_switch, l[6:5] == PRE_ZV ? SW_ZV : l[6:5] == PRE_CHG ? SW_CHG :
        l[6:5] == PRE_OD ? SW_OD : SW_NONE);
      `CHK(ctl.maker_len_max, m[5] ? 5'h1A : MAKER_SHORT);
      `CHK(ctl.product_len_max, m[5] ? 5'h16 : PRODUCT_SHORT);
      `CHK(ctl.cell_cmd_base, m[4] ? CELL_CMD_ALT : CELL_CMD_STD);
      `CHK(ctl.chg_current_rpt, m[3] ? VALUE_ZERO : meas.chg_current_req);
      `CHK(ctl.chg_voltage_rpt, m[1] ? VALUE_ZERO : meas.chg_voltage_req);
      `CHK(ctl.relative_charge_percent, m[2] ? SOC_CAP : 8'h64);
      `CHK(ctl.absolute_charge_percent, m[2] ? SOC_CAP : 8'h64);
      // a rewrite without reset must leave the sampled options alone
      wr(OFS_GAUGE, g ^ 8'h08);
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK(ctl.edv_voltage, g[3] ? meas.pack_mv : meas.lowest_cell_mv);
      // termination, midrange and front end events in one cycle
      @(posedge sys_clk);
      meas.term_valid <= 1'h1;
      meas.midrange_done <= 1'h1;
      meas.discharging_flag <= 1'h0;
      meas.full_charge_capacity <= d[15:0];
      meas.sync_percent <= 8'h5A;
      meas.afe_comm_error <= 1'h1;
      meas.pf_front_end_enable <= d[1];
      meas.highest_cell_mv <= 16'h1000;
      meas.cell_count <= 3'h4;
      meas.safety_ov_limit <= 16'h3000;
      @(posedge sys_clk);
      meas.term_valid <= 1'h0;
      meas.midrange_done <= 1'h0;
      #1;
      `CHK(ctl.rm_load, g[6]);
      `CHK(ctl.rm_load_value, d[15:0] * 90 / 100);
      `CHK(ctl.one_time_done, g[0]);
      `CHK(ctl.fe_perm_fail, h[5] && d[1]);
      `CHK(ctl.safety_over, (g[2] ? 16'h4000 : meas.pack_mv) > 16'h3000);
      @(posedge sys_clk);
      meas.fail_chg_set <= 1'h1;
      #1;
      `CHK(ctl.rm_load, 1'h0);
      `CHK(ctl.midrange_run, g[1]);
      `CHK(ctl.chg_fet_on, l[3]);
      `CHK(ctl.relative_charge_percent, 8'h64);
      // charge failure, opposite current, then pack removal
      @(posedge sys_clk);
      meas.fail_chg_set <= 1'h0;
      meas.current_discharge <= 1'h1;
      @(posedge sys_clk);
      meas.current_discharge <= 1'h0;
      sys_present_pin <= 1'h1;
      #1;
      `CHK(ctl.fail_chg, !l[4]);
      `CHK(ctl.dsg_fet_on, l[4]);
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK(ctl.fail_chg, 1'h0);
      // bus idle low, overtemperature in charge and a raw cell flag
      @(posedge sys_clk);
      sys_present_pin <= 1'h0;
      smbus_clk_pin <= 1'h0;
      smbus_data_pin <= 1'h0;
      meas.ot_charge <= 1'h1;
      meas.cell_over_raw <= 1'h1;
      repeat (5) @(posedge sys_clk);
      #1;
      `CHK(ctl.cell_over_flag, !h[0]);
      `CHK(ctl.chg_fet_on, !h[3] && l[3]);
      `CHK(ctl.dsg_fet_on, !(h[3] && !l[0]));
      repeat (10) @(posedge sys_clk);
      #1;
      `CHK(ctl.sleep_active, 1'h0);
      `CHK(ctl.cell_over_flag, 1'h1);
      repeat (10) @(posedge sys_clk);
      #1;
      `CHK(ctl.sleep_active, !h[4]);
      rd(OFS_STATUS, {3'h0, !h[4], 3'h1, g[0]});
      @(posedge sys_clk);
      smbus_clk_pin <= 1'h1;
      smbus_data_pin <= 1'h1;
    end
    conclude();
  end
endmodule
